// file: hw/cpfa_pkg.sv
// Package of constants and carrier types for the cell protection arbiter
package cpfa_pkg;
   // Clock rate and counter geometry
   localparam int CLK_MHZ = 250;
   localparam int CNT_W = 20;
   localparam int SHORT_SHIFT = 8;
   // Charger over-voltage return time, typical, in microseconds
   localparam int COV_RET_US = 1500;
   localparam int COV_RET_CYC = COV_RET_US * CLK_MHZ;
   // Detection time for charger over-voltage, internally fixed, in cycles
   localparam int COV_DET_CYC = 4000;
   // Counter-derived delays in cycles, plain defaults
   localparam int OC_DET_CYC = 4000;
   localparam int OC_RET_CYC = 1000;
   localparam int OD_DET_CYC = 2000;
   localparam int OD_RET_CYC = 1000;
   localparam int CUR_DET_CYC = 1000;
   localparam int CUR_RET_CYC = 1000;
   localparam int SC_DET_CYC = 64;
   // Channel indices of the detection engines
   localparam int CH_OC = 0;
   localparam int CH_OD = 1;
   localparam int CH_CUR = 2;
   localparam int CH_SC = 3;
   localparam int CH_COV = 4;
   localparam int N_CH = 5;
   // Register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // Field positions
   localparam int CTRL_SHORT_BIT = 0;
   localparam int ST_CHG_BIT = 5;
   localparam int ST_DIS_BIT = 6;
   localparam int ST_PUP_BIT = 7;
   localparam int ST_PDN_BIT = 8;
   localparam int ST_STBY_BIT = 9;
   localparam int ST_SHORT_BIT = 10;
   localparam int ST_AFTER_OC_BIT = 11;
   // Reset values and bus responses
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Comparator flags as they arrive from the analog front end
   typedef struct packed {
      logic shorten;  // Delay-shorten pin, high when tied to supply
      logic zero_v;   // 0V cell charging allowed
      logic cov;      // Charger over-voltage
      logic sc;       // Short circuit
      logic cur;      // Over-current
      logic od;       // Over-discharge
      logic oc;       // Over-charge
   } cpfa_flags_t;

   // Gate and return-pull levels driven toward the power stage
   typedef struct packed {
      logic standby;
      logic pull_down;  // Charger-minus node to negative supply
      logic pull_up;    // Charger-minus node to positive supply
      logic dis_gate;
      logic chg_gate;
   } cpfa_drive_t;
endpackage

// file: hw/cpfa_arbiter.sv
// Cell protection fault arbiter with AXI4-Lite status and control
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cpfa_arbiter #(
   parameter int OC_DET = cpfa_pkg::OC_DET_CYC,
   parameter int OC_RET = cpfa_pkg::OC_RET_CYC,
   parameter int OD_DET = cpfa_pkg::OD_DET_CYC,
   parameter int OD_RET = cpfa_pkg::OD_RET_CYC,
   parameter int CUR_DET = cpfa_pkg::CUR_DET_CYC,
   parameter int CUR_RET = cpfa_pkg::CUR_RET_CYC,
   parameter int SC_DET = cpfa_pkg::SC_DET_CYC,
   parameter int COV_DET = cpfa_pkg::COV_DET_CYC,
   parameter int COV_RET = cpfa_pkg::COV_RET_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire cpfa_pkg::cpfa_flags_t flags_async,
   output cpfa_pkg::cpfa_drive_t drive,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NF = $bits(cpfa_pkg::cpfa_flags_t);
   localparam int N = cpfa_pkg::N_CH;
   localparam int W = cpfa_pkg::CNT_W;

   // Terminal counts per channel; charger over-voltage is never shortened
   localparam int DET_TC [N] = '{OC_DET, OD_DET, CUR_DET, SC_DET, COV_DET};
   localparam int RET_TC [N] = '{OC_RET, OD_RET, CUR_RET, 1, COV_RET};
   localparam logic [N-1:0] SHORTABLE = 5'h0f;

   logic [NF-1:0] meta_reg, meta_next;
   logic [NF-1:0] sync_reg, sync_next;
   cpfa_pkg::cpfa_flags_t f;
   logic [31:0] ctrl_reg, ctrl_next;
   logic shorten;
   logic [N-1:0] det_cond, ret_cond, det_vec;
   logic after_oc_reg, after_oc_next;
   cpfa_pkg::cpfa_drive_t drive_reg, drive_next;

   // Two-stage synchroniser for every comparator flag and the pin
   // synchronise flags
   always_comb begin
      meta_next = flags_async;
      sync_next = meta_reg;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end
   assign f = cpfa_pkg::cpfa_flags_t'(sync_reg);

   assign shorten = f.shorten | ctrl_reg[cpfa_pkg::CTRL_SHORT_BIT];

   // Arbitration of which engines may count detection or return
   always_comb begin
      det_cond = '0;
      ret_cond = '0;
      det_cond[cpfa_pkg::CH_OC] = f.oc;
      det_cond[cpfa_pkg::CH_OD] = f.od & ~(f.oc & ~det_vec[cpfa_pkg::CH_OC]);
      det_cond[cpfa_pkg::CH_CUR] = f.cur & ~det_vec[cpfa_pkg::CH_OC]
         & ~det_vec[cpfa_pkg::CH_OD];
      det_cond[cpfa_pkg::CH_SC] = f.sc;
      det_cond[cpfa_pkg::CH_COV] = f.cov & drive_reg.dis_gate;
      ret_cond[cpfa_pkg::CH_OC] = ~f.oc;
      ret_cond[cpfa_pkg::CH_OD] = ~f.od;
      ret_cond[cpfa_pkg::CH_CUR] = ~f.cur & ~f.sc;
      ret_cond[cpfa_pkg::CH_SC] = ~f.sc & ~f.cur;
      ret_cond[cpfa_pkg::CH_COV] = ~f.cov;
   end

   // One timer engine per detection channel
   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_ch
         logic [W-1:0] cnt_reg, cnt_next;
         logic det_reg, det_next;
         logic [W-1:0] tc_det, tc_ret;
         always_comb begin
            tc_det = W'(DET_TC[gi]);
            tc_ret = W'(RET_TC[gi]);
            if (shorten && SHORTABLE[gi]) begin
               tc_det = tc_det >> cpfa_pkg::SHORT_SHIFT;
               tc_ret = tc_ret >> cpfa_pkg::SHORT_SHIFT;
            end
            if (tc_det == '0) tc_det = W'(1);
            if (tc_ret == '0) tc_ret = W'(1);
         end
         // Count while the condition holds; any drop restarts the wait
         always_comb begin
            cnt_next = '0;
            det_next = det_reg;
            if (!det_reg) begin
               if (det_cond[gi]) begin
                  if (cnt_reg >= tc_det - W'(1)) det_next = 1'b1;
                  else cnt_next = cnt_reg + W'(1);
               end
            end else if (ret_cond[gi]) begin
               if (cnt_reg >= tc_ret - W'(1)) det_next = 1'b0;
               else cnt_next = cnt_reg + W'(1);
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_reg <= '0;
               det_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_next;
               det_reg <= det_next;
            end
         end
         assign det_vec[gi] = det_reg;
      end
   endgenerate

   // Gate, pull and standby levels, registered so outputs are clean
   always_comb begin
      logic od_d, dis_fault;
      od_d = det_vec[cpfa_pkg::CH_OD];
      dis_fault = od_d | det_vec[cpfa_pkg::CH_CUR] | det_vec[cpfa_pkg::CH_SC];
      after_oc_next = after_oc_reg;
      // Remember whether over-discharge completed under over-charge
      if (!od_d) after_oc_next = 1'b0;
      else if (!drive_reg.pull_up) after_oc_next = det_vec[cpfa_pkg::CH_OC];
      drive_next.dis_gate = ~dis_fault;
      drive_next.chg_gate = ~(det_vec[cpfa_pkg::CH_OC]
         | det_vec[cpfa_pkg::CH_COV]) | f.zero_v;
      drive_next.pull_up = od_d;
      drive_next.pull_down = ~od_d
         & (det_vec[cpfa_pkg::CH_CUR] | det_vec[cpfa_pkg::CH_SC]);
      drive_next.standby = od_d & ~after_oc_next;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         after_oc_reg <= 1'b0;
         drive_reg <= cpfa_pkg::cpfa_drive_t'(5'h03);
      end else begin
         after_oc_reg <= after_oc_next;
         drive_reg <= drive_next;
      end
   end
   assign drive = drive_reg;

   // AXI4-Lite slave: address and data taken in either order
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [3:0] waddr_reg, waddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next, status;

   // Status word built from live block state
   always_comb begin
      status = '0;
      status[N-1:0] = det_vec;
      status[cpfa_pkg::ST_CHG_BIT] = drive_reg.chg_gate;
      status[cpfa_pkg::ST_DIS_BIT] = drive_reg.dis_gate;
      status[cpfa_pkg::ST_PUP_BIT] = drive_reg.pull_up;
      status[cpfa_pkg::ST_PDN_BIT] = drive_reg.pull_down;
      status[cpfa_pkg::ST_STBY_BIT] = drive_reg.standby;
      status[cpfa_pkg::ST_SHORT_BIT] = shorten;
      status[cpfa_pkg::ST_AFTER_OC_BIT] = after_oc_reg;
   end

   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_hold_next = 1'b1;
         waddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_hold_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
      // Commit once both halves are held and no response is pending
      if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = cpfa_pkg::RESP_OKAY;
         if (waddr_reg[3:2] == cpfa_pkg::ADDR_CTRL[3:2]) begin
            for (int b = 0; b < 4; b++) begin
               if (wstrb_reg[b]) ctrl_next[8*b +: 8] = wdata_reg[8*b +: 8];
            end
         end else if (waddr_reg[3:2] != cpfa_pkg::ADDR_STATUS[3:2]) begin
            bresp_next = cpfa_pkg::RESP_SLVERR;
         end
      end
      // Only bit 0 of control is implemented; others read as zero
      ctrl_next[31:1] = '0;
      if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = cpfa_pkg::RESP_OKAY;
         rdata_next = '0;
         if (s_axi_araddr[3:2] == cpfa_pkg::ADDR_CTRL[3:2]) begin
            rdata_next = ctrl_reg;
         end else if (s_axi_araddr[3:2] == cpfa_pkg::ADDR_STATUS[3:2]) begin
            rdata_next = status;
         end else begin
            rresp_next = cpfa_pkg::RESP_SLVERR;
         end
      end
      // Ready drops while a half is held so payloads are never overwritten
      awready_next = ~aw_hold_next & ~bvalid_next;
      wready_next = ~w_hold_next & ~bvalid_next;
      arready_next = ~rvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= cpfa_pkg::RESP_OKAY;
         ctrl_reg <= cpfa_pkg::CTRL_RST;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= cpfa_pkg::RESP_OKAY;
         rdata_reg <= '0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         ctrl_reg <= ctrl_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
endmodule
`default_nettype wire

// file: bench/cpfa_arbiter_props.sv
// Concurrent checks on the arbiter gate and pull outputs
`timescale 1ns/1ps
`default_nettype none
module cpfa_arbiter_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire cpfa_pkg::cpfa_flags_t flags_async,
   input wire cpfa_pkg::cpfa_drive_t drive
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Zero volt flag held long enough to pass the synchroniser
   sequence s_zero_held;
      flags_async.zero_v [*4];
   endsequence
   // A timer-made change shows four edges after the flag that caused it:
   // two sync flops, the timer edge and the output flop
   sequence s_dis_fell;
      $fell(drive.dis_gate);
   endsequence
   a_rst_idle: assert property (
      disable iff (1'h0) !aresetn |=> drive == 5'h03)
      else $error("Outputs not idle after reset");
   a_zero_chg: assert property (
      s_zero_held |=> drive.chg_gate)
      else $error("Charge gate low while zero volt flag held");
   a_pull_excl: assert property (
      !(drive.pull_up && drive.pull_down))
      else $error("Both return pulls enabled");
   a_stby_pull: assert property (
      drive.standby |-> drive.pull_up && !drive.dis_gate)
      else $error("Standby without positive pull and gate off");
   a_pdn_dis: assert property (
      drive.pull_down |-> !drive.dis_gate)
      else $error("Negative pull with discharge gate on");
   a_dis_cause: assert property (
      s_dis_fell |-> $past(flags_async.od | flags_async.cur
      | flags_async.sc, 4))
      else $error("Discharge gate fell without a cause");
   a_chg_cause: assert property (
      $fell(drive.chg_gate) |-> $past(flags_async.oc | flags_async.cov, 4))
      else $error("Charge gate fell without a cause");
   a_cov_block: assert property (
      $fell(drive.chg_gate) && !$past(flags_async.oc, 4)
      |-> $past(drive.dis_gate, 2))
      else $error("Over-voltage detected while discharge gate low");
   a_chg_rise: assert property (
      $rose(drive.chg_gate) |-> $past(flags_async.zero_v, 3)
      || !$past(flags_async.oc | flags_async.cov, 3))
      else $error("Charge gate rose while its cause held");
   a_stby_cause: assert property (
      $rose(drive.standby) |-> $past(flags_async.od, 4))
      else $error("Standby entered without over-discharge");
endmodule
bind cpfa_arbiter cpfa_arbiter_props i_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .flags_async(flags_async),
   .drive(drive)
);
`default_nettype wire

// file: bench/cpfa_fet_model.sv
// Power switch model behind the two gate outputs
`timescale 1ns/1ps
`default_nettype none
module cpfa_fet_model (
   input wire cpfa_pkg::cpfa_drive_t drive,
   output logic chg_on,
   output logic dis_on
);
   // gate low turns the switch off
   assign chg_on = drive.chg_gate;
   assign dis_on = drive.dis_gate;
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the cell protection arbiter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int OCD = 8, ODD = 12, CUD = 10, SCD = 4, CVD = 10, CVR = 20;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [6:0] fl = 7'h00;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, chg_on, dis_on;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   cpfa_pkg::cpfa_drive_t drv;
   int err_total = 0, compares = 0, cyc = 0;
   // Delays cut down so each scenario runs in tens of cycles
   cpfa_arbiter #(.OC_DET(OCD), .OC_RET(8), .OD_DET(ODD), .OD_RET(8),
      .CUR_DET(CUD), .CUR_RET(8), .SC_DET(SCD), .COV_DET(CVD),
      .COV_RET(CVR)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .flags_async(cpfa_pkg::cpfa_flags_t'(fl)), .drive(drv),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cpfa_fet_model i_fet (.drive(drv), .chg_on(chg_on), .dis_on(dis_on));
   // Free running 250 MHz clock
   initial begin
      forever #2 aclk = ~aclk;
   end
   task automatic end_of_test();
      $display("Mismatches %0d in %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // A hung handshake must still reach the verdict
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Counts edges until a drive bit reaches a level, checks the window
   task automatic wb(input int b, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (drv[b] !== v && n <= hi) begin
         @(posedge aclk);
         n++;
      end
      compares++;
      if (n < lo || n > hi) begin
         err_total++;
         $display("[FAIL] drive bit %0d expected %0d..%0d seen %0d",
            b, lo, hi, n);
      end
   endtask
   task automatic hold(input int n, input int b, input logic v);
      repeat (n) begin
         @(posedge aclk);
         chk("held bit", 32'(v), 32'(drv[b]));
      end
   endtask
   task automatic setf(input logic [6:0] m);
      @(posedge aclk);
      fl <= m;
   endtask
   task automatic do_reset();
      @(posedge aclk);
      fl <= 7'h00;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rready <= 1'h0;
      chk("rdata", ed, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   task automatic t_regs();
      chk("idle", 32'h03, 32'(drv));
      chk("dis_on", 32'h1, 32'(dis_on));
      rd(4'h4, 32'h60, 2'h0);
      rd(4'h8, 32'h0, 2'h2);
      wr(4'h8, 32'h1, 2'h2);
      wr(4'h4, 32'hffff, 2'h0);
      wr(4'h0, 32'h1, 2'h0);
      rd(4'h0, 32'h1, 2'h0);
      rd(4'h4, 32'h460, 2'h0);
      wr(4'h0, 32'h0, 2'h0);
   endtask
   task automatic t_cov();
      setf(7'h10);
      repeat (CVD - 3) @(posedge aclk);
      setf(7'h00);
      hold(CVD + 6, 0, 1'h1);
      setf(7'h10);
      wb(0, 1'h0, CVD, CVD + 6);
      setf(7'h00);
      wb(0, 1'h1, CVR, CVR + 6);
   endtask
   task automatic t_ocur();
      do_reset();
      setf(7'h05);
      wb(0, 1'h0, OCD, OCD + 6);
      hold(CUD + 6, 1, 1'h1);
      chk("pulls", 32'h0, 32'(drv[3:2]));
      do_reset();
      setf(7'h04);
      wb(1, 1'h0, CUD, CUD + 6);
      chk("pd stby", 32'h1, 32'(drv[4:3]));
      setf(7'h05);
      wb(0, 1'h0, OCD, OCD + 6);
      chk("pull_down", 32'h1, 32'(drv[3]));
      setf(7'h06);
      repeat (ODD + 6) @(posedge aclk);
      chk("stby pulls", 32'h5, 32'(drv[4:2]));
      // Over-current raised late, so it is still pending when
      // over-discharge completes; only the status word shows it was dropped
      do_reset();
      setf(7'h02);
      repeat (6) @(posedge aclk);
      setf(7'h06);
      wb(1, 1'h0, ODD - 8, ODD - 2);
      hold(CUD + 6, 1, 1'h0);
      rd(4'h4, 32'h2a2, 2'h0);
   endtask
   task automatic t_od();
      do_reset();
      setf(7'h02);
      wb(1, 1'h0, ODD, ODD + 6);
      chk("stby pulls", 32'h5, 32'(drv[4:2]));
      chk("dis_on", 32'h0, 32'(dis_on));
      setf(7'h12);
      hold(CVD + 6, 0, 1'h1);
      setf(7'h10);
      wb(1, 1'h1, 8, 14);
      wb(0, 1'h0, CVD, CVD + 6);
      do_reset();
      setf(7'h03);
      wb(0, 1'h0, OCD, OCD + 6);
      wb(1, 1'h0, ODD, ODD + 6);
      chk("stby pulls", 32'h1, 32'(drv[4:2]));
   endtask
   task automatic t_mix();
      do_reset();
      setf(7'h01);
      wb(0, 1'h0, OCD, OCD + 6);
      setf(7'h09);
      wb(1, 1'h0, SCD, SCD + 6);
      chk("pd stby", 32'h1, 32'(drv[4:3]));
      setf(7'h29);
      wb(0, 1'h1, 0, 4);
      do_reset();
      setf(7'h40);
      repeat (3) @(posedge aclk);
      setf(7'h41);
      wb(0, 1'h0, 1, 6);
      do_reset();
      setf(7'h50);
      wb(0, 1'h0, CVD, CVD + 6);
   endtask
   // Main sequence
   initial begin
      do_reset();
      t_regs();
      t_cov();
      t_ocur();
      t_od();
      t_mix();
      end_of_test();
   end
endmodule
`default_nettype wire
